// *** icd_map.vh ***
// Address decode, register offsets, field positions and descriptor layout of the cascaded DMA controller.
// Included by every design file except the channel; holds definitions only.
`ifndef ICD_MAP_VH
`define ICD_MAP_VH

// Upper address bits that select each register group in ISA I/O space.
`define ICD_C1_HI     12'h000
`define ICD_C2_HI     11'h006
`define ICD_PG_HI     12'h008
`define ICD_SG_HI     14'h0104
`define ICD_SGP_HI    14'h0105

// Offsets inside a controller (second controller uses word-spaced addresses).
`define ICD_OFF_STAT  4'h8
`define ICD_OFF_REQ   4'h9
`define ICD_OFF_SMASK 4'hA
`define ICD_OFF_MODE  4'hB
`define ICD_OFF_CLRBP 4'hC
`define ICD_OFF_MCLR  4'hD
`define ICD_OFF_CLRMK 4'hE
`define ICD_OFF_AMASK 4'hF

// Command, mode and scatter/gather command fields.
`define ICD_CMD_DIS   2
`define ICD_MODE_AUTO 4
`define ICD_MODE_DOWN 5
`define ICD_TYP_VFY   2'h0
`define ICD_TYP_WRMEM 2'h1
`define ICD_MOD_CASC  2'h3
`define ICD_SG_START  0
`define ICD_SG_STOP   1
`define ICD_CASC_CH   3'h4
// Cycles after a grant during which no new grant is made.
`define ICD_GRANT_GAP 2'h3

// Descriptor: word 0 memory address, word 1 count minus one with end-of-list flag.
`define ICD_DESC_LAST 31
`define ICD_DESC_CNT  32'h0000_0004
`define ICD_DESC_STEP 32'h0000_0008

// Memory access sizes.
`define ICD_SZ_BYTE   2'h0
`define ICD_SZ_WORD   2'h1
`define ICD_SZ_DWORD  2'h2

`endif

// *** icd_chan.v ***
// One DMA channel: base and current address and count with byte-wise loading.
// Assumes write strobes are single-cycle pulses on the internal clock.
`timescale 1ns/1ps
`default_nettype none
module icd_chan
(
    input  wire        clk,
    input  wire        rst_int_b,
    input  wire        wr_addr,
    input  wire        wr_cnt,
    input  wire        wr_hi,
    input  wire [7:0]  wdata,
    input  wire        step,
    input  wire        down,
    input  wire        autoinit,
    input  wire        load,
    input  wire [15:0] load_addr,
    input  wire [15:0] load_cnt,
    output wire [15:0] cur_addr,
    output wire [15:0] cur_cnt,
    output wire        tc_now
);
    reg [15:0] base_addr_q;
    reg [15:0] base_cnt_q;
    reg [15:0] cur_addr_q;
    reg [15:0] cur_cnt_q;

    assign cur_addr = cur_addr_q;
    assign cur_cnt  = cur_cnt_q;
    assign tc_now   = (cur_cnt_q == 16'h0000);

    always @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            base_addr_q <= 16'h0000;
            base_cnt_q  <= 16'h0000;
            cur_addr_q  <= 16'h0000;
            cur_cnt_q   <= 16'h0000;
        end
        else if (wr_addr)
        begin
            if (wr_hi)
            begin
                base_addr_q[15:8] <= wdata;
                cur_addr_q[15:8]  <= wdata;
            end
            else
            begin
                base_addr_q[7:0] <= wdata;
                cur_addr_q[7:0]  <= wdata;
            end
        end
        else if (wr_cnt)
        begin
            if (wr_hi)
            begin
                base_cnt_q[15:8] <= wdata;
                cur_cnt_q[15:8]  <= wdata;
            end
            else
            begin
                base_cnt_q[7:0] <= wdata;
                cur_cnt_q[7:0]  <= wdata;
            end
        end
        else if (load)
        begin
            base_addr_q <= load_addr;
            cur_addr_q  <= load_addr;
            base_cnt_q  <= load_cnt;
            cur_cnt_q   <= load_cnt;
        end
        else if (step)
        begin
            // Auto-initialise refills from the base copies once the count has run out.
            if (tc_now && autoinit)
            begin
                cur_addr_q <= base_addr_q;
                cur_cnt_q  <= base_cnt_q;
            end
            else
            begin
                cur_addr_q <= down ? cur_addr_q - 16'h0001 : cur_addr_q + 16'h0001;
                cur_cnt_q  <= cur_cnt_q - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// *** icd_sg.v ***
// Scatter/gather walker: fetches two-word descriptors and loads one channel per descriptor.
// Assumes fetch_ack answers fetch_req some clocks later and chan_done pulses at the channel's final transfer.
`timescale 1ns/1ps
`default_nettype none
module icd_sg
(
    input  wire        clk,
    input  wire        rst_int_b,
    input  wire        start,
    input  wire        stop,
    input  wire [31:0] ptr_in,
    input  wire        fetch_ack,
    input  wire [31:0] fetch_data,
    input  wire        chan_done,
    output wire        fetch_req,
    output wire [31:0] fetch_addr,
    output reg         load,
    output reg  [23:0] load_addr,
    output reg  [15:0] load_cnt,
    output wire        busy,
    output reg         last_q
);
    `include "icd_map.vh"
    localparam SG_IDLE = 2'd0;
    localparam SG_RD0  = 2'd1;
    localparam SG_RD1  = 2'd2;
    localparam SG_RUN  = 2'd3;

    reg [1:0]  st_q;
    reg [31:0] ptr_q;

    assign fetch_req  = (st_q == SG_RD0) || (st_q == SG_RD1);
    assign fetch_addr = (st_q == SG_RD1) ? ptr_q + `ICD_DESC_CNT : ptr_q;
    assign busy       = (st_q != SG_IDLE);

    always @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            st_q      <= SG_IDLE;
            ptr_q     <= 32'h0000_0000;
            load      <= 1'b0;
            load_addr <= 24'h00_0000;
            load_cnt  <= 16'h0000;
            last_q    <= 1'b0;
        end
        else
        begin
            load <= 1'b0;
            if (stop)
                st_q <= SG_IDLE;
            else
            begin
                case (st_q)
                SG_IDLE:
                    if (start)
                    begin
                        ptr_q <= ptr_in;
                        st_q  <= SG_RD0;
                    end
                SG_RD0:
                    if (fetch_ack)
                    begin
                        load_addr <= fetch_data[23:0];
                        st_q      <= SG_RD1;
                    end
                SG_RD1:
                    if (fetch_ack)
                    begin
                        load_cnt <= fetch_data[15:0];
                        last_q   <= fetch_data[`ICD_DESC_LAST];
                        load     <= 1'b1;
                        st_q     <= SG_RUN;
                    end
                SG_RUN:
                    if (chan_done)
                    begin
                        if (last_q)
                            st_q <= SG_IDLE;
                        else
                        begin
                            ptr_q <= ptr_q + `ICD_DESC_STEP;
                            st_q  <= SG_RD0;
                        end
                    end
                default:
                    st_q <= SG_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** icd_top.v ***
// Cascaded ISA DMA controller: ISA I/O register slave, two controllers, channel engine, S/G walker.
// Assumes ISA pins and device requests are asynchronous; memory port runs on clk.
// Behaviour
// - Two controllers; the first feeds the second through a cascade channel.
// - Channels 0-3 move single bytes, counts in bytes.
// - Channels 5-7 move 2-byte words, counts in words.
// - Bus masters on a cascade-mode channel are not limited by group width.
// - Channel 4 only cascades; it never moves data for a slave.
// - Plain mode takes everything from registers; one buffer per channel.
// - S/G mode walks memory descriptor lists from a software-given start pointer.
// - Software start and stop commands begin or end list walking.
// - Registers answer ISA I/O accesses only.
// - No extra register is needed for correct operation.
// - Address or count write loads base and current; read returns current.
// - First-controller offset 8 reads status, writes command.
`timescale 1ns/1ps
`default_nettype none
module icd_top
(
    input  wire        clk,
    input  wire        rst_b,
    input  wire [15:0] io_addr,
    input  wire        io_rd_b,
    input  wire        io_wr_b,
    input  wire [7:0]  io_data_in,
    output reg  [7:0]  io_data_out_q,
    output reg         io_data_oe_q,
    input  wire [7:0]  dreq,
    output reg  [7:0]  dack_q,
    output reg         eop_q,
    output reg         mem_req_q,
    output reg  [31:0] mem_addr_q,
    output reg         mem_wr_q,
    output reg  [1:0]  mem_size_q,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata
);
    `include "icd_map.vh"
    localparam ST_IDLE  = 2'd0;
    localparam ST_XFER  = 2'd1;
    localparam ST_CASC  = 2'd2;
    localparam ST_FETCH = 2'd3;

    // Page register address to channel; bit 3 marks a valid page location.
    function [3:0] pg_map;
        input [3:0] o;
        begin
            case (o)
            4'h7:    pg_map = 4'h8;
            4'h3:    pg_map = 4'h9;
            4'h1:    pg_map = 4'hA;
            4'h2:    pg_map = 4'hB;
            4'hB:    pg_map = 4'hD;
            4'h9:    pg_map = 4'hE;
            4'hA:    pg_map = 4'hF;
            default: pg_map = 4'h0;
            endcase
        end
    endfunction

    // Fixed priority, lowest channel first; bit 3 marks a winner.
    function [3:0] pick;
        input [7:0] p;
        integer i;
        begin
            pick = 4'h0;
            for (i = 7; i >= 0; i = i - 1)
                if (p[i])
                    pick = {1'b1, i[2:0]};
        end
    endfunction

    reg rst_s1_q;
    reg rst_int_b;
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_q  <= 1'b0;
            rst_int_b <= 1'b0;
        end
        else
        begin
            rst_s1_q  <= 1'b1;
            rst_int_b <= rst_s1_q;
        end
    end

    reg [15:0] a_s1_q, a_q;
    reg [7:0]  d_s1_q, d_q;
    reg [7:0]  dr_s1_q, dr_q;
    reg        rd_s1_q, rd_s2_q, rd_s3_q;
    reg        wr_s1_q, wr_s2_q, wr_s3_q;
    always @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            a_s1_q  <= 16'h0000;
            a_q     <= 16'h0000;
            d_s1_q  <= 8'h00;
            d_q     <= 8'h00;
            dr_s1_q <= 8'h00;
            dr_q    <= 8'h00;
            {rd_s1_q, rd_s2_q, rd_s3_q} <= 3'h7;
            {wr_s1_q, wr_s2_q, wr_s3_q} <= 3'h7;
        end
        else
        begin
            a_s1_q  <= io_addr;
            a_q     <= a_s1_q;
            d_s1_q  <= io_data_in;
            d_q     <= d_s1_q;
            dr_s1_q <= dreq;
            dr_q    <= dr_s1_q;
            {rd_s1_q, rd_s2_q, rd_s3_q} <= {io_rd_b, rd_s1_q, rd_s2_q};
            {wr_s1_q, wr_s2_q, wr_s3_q} <= {io_wr_b, wr_s1_q, wr_s2_q};
        end
    end

    wire       wstb = wr_s3_q & ~wr_s2_q;
    wire       rend = ~rd_s3_q & rd_s2_q;
    // Only I/O strobes reach this decode; there is no memory-space path.
    wire       c1   = (a_q[15:4] == `ICD_C1_HI);
    wire       c2   = (a_q[15:5] == `ICD_C2_HI) & ~a_q[0];
    wire [3:0] off  = c2 ? a_q[4:1] : a_q[3:0];
    wire       chr  = (c1 | c2) & ~off[3];
    wire [2:0] rch  = {c2, off[2:1]};
    wire       pgh  = (a_q[15:4] == `ICD_PG_HI);
    wire [3:0] pgm  = pg_map(a_q[3:0]);
    wire       sgc  = (a_q[15:2] == `ICD_SG_HI) & (a_q[1:0] == 2'h0);
    wire       sgp  = (a_q[15:2] == `ICD_SGP_HI);

    reg [7:0]  cmd1_q, cmd2_q, mask_q, sreq_q, tcst_q;
    reg [1:0]  bp_q;
    reg [7:0]  mode_q [0:7];
    reg [7:0]  page_q [0:7];
    reg [2:0]  sg_ch_q;
    reg [31:0] sg_ptr_q;
    reg        sg_start_q, sg_stop_q;
    reg [1:0]  st_q;
    reg [2:0]  ch_q;
    reg        vfy_q;
    reg [1:0]  hold_q;

    wire        bp = c2 ? bp_q[1] : bp_q[0];
    wire [127:0] cur_addr_v, cur_cnt_v;
    wire [7:0]   tc_v;
    wire         sg_fetch, sg_load, sg_busy, sg_last;
    wire [31:0]  sg_faddr;
    wire [23:0]  sg_laddr;
    wire [15:0]  sg_lcnt;

    wire [7:0] raw   = dr_q | sreq_q;
    wire       dis2  = cmd2_q[`ICD_CMD_DIS];
    wire       dis1  = cmd1_q[`ICD_CMD_DIS] | dis2 | mask_q[4];
    wire [7:0] pend  = raw & ~mask_q & {{3{~dis2}}, 1'b0, {4{~dis1}}};
    wire [3:0] win   = pick(pend);
    wire [7:0] wmode = mode_q[win[2:0]];
    wire [15:0] waddr = cur_addr_v[win[2:0]*16 +: 16];
    wire [7:0] wpage = page_q[win[2:0]];
    wire       step_now = (st_q == ST_XFER) & (mem_ack | vfy_q);
    wire       done_tc  = step_now & tc_v[ch_q];
    wire       sg_done  = done_tc & (ch_q == sg_ch_q);
    wire       fetch_ack = (st_q == ST_FETCH) & mem_ack;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : gch
            wire sel = wstb & chr & (rch == g);
            icd_chan u_chan
            (
                .clk       (clk),
                .rst_int_b (rst_int_b),
                .wr_addr   (sel & ~off[0]),
                .wr_cnt    (sel & off[0]),
                .wr_hi     (bp),
                .wdata     (d_q),
                .step      (step_now & (ch_q == g)),
                .down      (mode_q[g][`ICD_MODE_DOWN]),
                .autoinit  (mode_q[g][`ICD_MODE_AUTO]),
                .load      (sg_load & (sg_ch_q == g)),
                .load_addr (g >= 4 ? sg_laddr[16:1] : sg_laddr[15:0]),
                .load_cnt  (sg_lcnt),
                .cur_addr  (cur_addr_v[g*16 +: 16]),
                .cur_cnt   (cur_cnt_v[g*16 +: 16]),
                .tc_now    (tc_v[g])
            );
        end
    endgenerate

    icd_sg u_sg
    (
        .clk        (clk),
        .rst_int_b  (rst_int_b),
        .start      (sg_start_q),
        .stop       (sg_stop_q),
        .ptr_in     (sg_ptr_q),
        .fetch_ack  (fetch_ack),
        .fetch_data (mem_rdata),
        .chan_done  (sg_done),
        .fetch_req  (sg_fetch),
        .fetch_addr (sg_faddr),
        .load       (sg_load),
        .load_addr  (sg_laddr),
        .load_cnt   (sg_lcnt),
        .busy       (sg_busy),
        .last_q     (sg_last)
    );

    reg [7:0] rdata;
    reg       rhit;
    always @*
    begin
        rdata = 8'h00;
        rhit  = 1'b1;
        if (chr)
        begin
            rdata = off[0] ? cur_cnt_v[rch*16 + bp*8 +: 8] : cur_addr_v[rch*16 + bp*8 +: 8];
        end
        else if ((c1 | c2) && off == `ICD_OFF_STAT)
            rdata = c2 ? {raw[7:4], tcst_q[7:4]} : {raw[3:0], tcst_q[3:0]};
        else if (pgh && pgm[3])
            rdata = page_q[pgm[2:0]];
        else if (sgc)
            rdata = {1'b0, sg_ch_q, 2'h0, sg_last, sg_busy};
        else if (sgp)
            rdata = sg_ptr_q[a_q[1:0]*8 +: 8];
        else
            rhit = (c1 | c2 | pgh);
    end

    wire [2:0] wch = {c2, d_q[1:0]};
    integer k;
    always @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            cmd1_q     <= 8'h00;
            cmd2_q     <= 8'h00;
            mask_q     <= 8'hFF;
            sreq_q     <= 8'h00;
            tcst_q     <= 8'h00;
            bp_q       <= 2'h0;
            sg_ch_q    <= 3'h0;
            sg_ptr_q   <= 32'h0000_0000;
            sg_start_q <= 1'b0;
            sg_stop_q  <= 1'b0;
            for (k = 0; k < 8; k = k + 1)
            begin
                mode_q[k] <= 8'h00;
                page_q[k] <= 8'h00;
            end
        end
        else
        begin
            sg_start_q <= 1'b0;
            sg_stop_q  <= 1'b0;
            if (rend && (c1 | c2) && off == `ICD_OFF_STAT)
                tcst_q[c2*4 +: 4] <= 4'h0;
            if (rend && chr)
                bp_q[c2] <= ~bp_q[c2];
            if (wstb && (c1 | c2))
            begin
                case (off)
                `ICD_OFF_STAT:
                    if (c2)
                        cmd2_q <= d_q;
                    else
                        cmd1_q <= d_q;
                `ICD_OFF_REQ:   sreq_q[wch] <= d_q[2];
                `ICD_OFF_SMASK: mask_q[wch] <= d_q[2];
                `ICD_OFF_MODE:  mode_q[wch] <= d_q;
                `ICD_OFF_CLRBP: bp_q[c2] <= 1'b0;
                `ICD_OFF_MCLR:
                begin
                    bp_q[c2]           <= 1'b0;
                    mask_q[c2*4 +: 4]  <= 4'hF;
                    sreq_q[c2*4 +: 4]  <= 4'h0;
                    tcst_q[c2*4 +: 4]  <= 4'h0;
                    if (c2)
                        cmd2_q <= 8'h00;
                    else
                        cmd1_q <= 8'h00;
                end
                `ICD_OFF_CLRMK: mask_q[c2*4 +: 4] <= 4'h0;
                `ICD_OFF_AMASK: mask_q[c2*4 +: 4] <= d_q[3:0];
                default:        bp_q[c2] <= ~bp_q[c2];
                endcase
            end
            if (wstb && pgh && pgm[3])
                page_q[pgm[2:0]] <= d_q;
            if (wstb && sgc)
            begin
                sg_ch_q    <= d_q[6:4];
                sg_start_q <= d_q[`ICD_SG_START];
                sg_stop_q  <= d_q[`ICD_SG_STOP];
            end
            if (wstb && sgp)
                sg_ptr_q[a_q[1:0]*8 +: 8] <= d_q;
            if (sg_load)
                page_q[sg_ch_q] <= sg_laddr[23:16];
            // Hardware sets are applied last so an event never loses to a software clear.
            if (done_tc)
            begin
                tcst_q[ch_q] <= 1'b1;
                sreq_q[ch_q] <= 1'b0;
                if (!mode_q[ch_q][`ICD_MODE_AUTO])
                    mask_q[ch_q] <= 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            st_q          <= ST_IDLE;
            ch_q          <= 3'h0;
            vfy_q         <= 1'b0;
            hold_q        <= 2'h0;
            dack_q        <= 8'h00;
            eop_q         <= 1'b0;
            mem_req_q     <= 1'b0;
            mem_addr_q    <= 32'h0000_0000;
            mem_wr_q      <= 1'b0;
            mem_size_q    <= `ICD_SZ_BYTE;
            io_data_out_q <= 8'h00;
            io_data_oe_q  <= 1'b0;
        end
        else
        begin
            io_data_out_q <= rdata;
            io_data_oe_q  <= ~rd_s2_q & rhit & (c1 | c2 | pgh | sgc | sgp);
            eop_q         <= done_tc;
            // A device drops its request only after it sees its grant.
            // The pin synchroniser adds two more cycles of delay.
            // Without this gap, a stale request would win a second transfer.
            if (hold_q != 2'h0)
                hold_q <= hold_q - 2'h1;
            case (st_q)
            ST_IDLE:
                if (sg_fetch)
                begin
                    mem_req_q  <= 1'b1;
                    mem_addr_q <= sg_faddr;
                    mem_wr_q   <= 1'b0;
                    mem_size_q <= `ICD_SZ_DWORD;
                    st_q       <= ST_FETCH;
                end
                else if (win[3] && hold_q == 2'h0)
                begin
                    hold_q       <= `ICD_GRANT_GAP;
                    ch_q         <= win[2:0];
                    dack_q[win[2:0]] <= 1'b1;
                    if (wmode[7:6] == `ICD_MOD_CASC)
                        st_q <= ST_CASC;
                    else
                    begin
                        vfy_q      <= (wmode[3:2] == `ICD_TYP_VFY);
                        mem_req_q  <= (wmode[3:2] != `ICD_TYP_VFY);
                        mem_wr_q   <= (wmode[3:2] == `ICD_TYP_WRMEM);
                        st_q       <= ST_XFER;
                        if (win[2])
                        begin
                            mem_addr_q <= {8'h00, wpage[7:1], waddr, 1'b0};
                            mem_size_q <= `ICD_SZ_WORD;
                        end
                        else
                        begin
                            mem_addr_q <= {8'h00, wpage, waddr};
                            mem_size_q <= `ICD_SZ_BYTE;
                        end
                    end
                end
            ST_XFER:
                if (step_now)
                begin
                    mem_req_q <= 1'b0;
                    dack_q    <= 8'h00;
                    vfy_q     <= 1'b0;
                    st_q      <= ST_IDLE;
                end
            ST_CASC:
                if (!raw[ch_q])
                begin
                    dack_q <= 8'h00;
                    st_q   <= ST_IDLE;
                end
            ST_FETCH:
                if (mem_ack)
                begin
                    mem_req_q <= 1'b0;
                    st_q      <= ST_IDLE;
                end
            default:
                st_q <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** icd_top_sva.sv ***
// Checker on the ports of the cascaded DMA controller top: grants, memory cycles and end-of-process pulse.
// Assumes the memory side answers each request with a one-cycle acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "icd_map.vh"
module icd_top_sva
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  dack_q,
    input wire logic        eop_q,
    input wire logic        mem_req_q,
    input wire logic [31:0] mem_addr_q,
    input wire logic        mem_wr_q,
    input wire logic [1:0]  mem_size_q,
    input wire logic        mem_ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_CASC_ONLY: assert property (dack_q[4] == 1'b0)
        else $error("cascade channel granted");
    AST_ONE_GRANT: assert property ($onehot0(dack_q))
        else $error("two channels granted");
    AST_BYTE_SIZE: assert property (mem_req_q && dack_q[3:0] != 4'h0 |-> mem_size_q == `ICD_SZ_BYTE)
        else $error("byte channel size wrong");
    AST_WORD_SIZE: assert property (mem_req_q && dack_q[7:5] != 3'h0 |-> mem_size_q == `ICD_SZ_WORD && !mem_addr_q[0])
        else $error("word channel size or alignment wrong");
    AST_DESC_FETCH: assert property (mem_req_q && dack_q == 8'h00 |-> mem_size_q == `ICD_SZ_DWORD && !mem_wr_q)
        else $error("descriptor fetch not a dword read");
    AST_REQ_HOLD: assert property (mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q))
        else $error("memory request dropped or moved early");
    AST_REQ_DROP: assert property (mem_req_q && mem_ack |=> !mem_req_q)
        else $error("memory request held after acknowledge");
    AST_EOP_PULSE: assert property (eop_q |-> ($past(mem_ack) && $past(dack_q) != 8'h00) ##1 !eop_q)
        else $error("end of process not a one-cycle pulse after a transfer");
endmodule
bind icd_top icd_top_sva icd_top_sva_i (.*);
`default_nettype wire

// *** icd_dev_model.sv ***
// Model of the ISA devices on the request pins: each raises a request when the bench asks.
// Assumes the bench changes want just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module icd_dev_model
(
    input  wire logic       clk,
    input  wire logic [7:0] want,
    input  wire logic [7:0] dack_q,
    output var  logic [7:0] dreq
);
    // A device lowers its request while acknowledged, so one grant is not asked for twice.
    initial dreq = 8'h00;
    always @(posedge clk)
        dreq <= #1 want & ~dack_q;
endmodule
`default_nettype wire

// *** tb.sv ***
// Bench for the cascaded DMA controller: register access, byte, word and descriptor transfers.
// Assumes the checker is bound to icd_top and the device model drives the request pins.
`timescale 1ns/1ps
`default_nettype none
`include "icd_map.vh"
module tb;
    logic        clk = 0, rst_b = 0, io_rd_b = 1, io_wr_b = 1, mem_ack = 0, eop_seen = 0;
    logic        io_data_oe_q, eop_q, mem_req_q, mem_wr_q, lwr;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0]  io_data_in = 8'h00, want = 8'h00, io_data_out_q, dreq, dack_q;
    logic [1:0]  mem_size_q, lsz;
    logic [31:0] mem_addr_q, mem_rdata, la;
    logic [8:0]  q;
    int          fails = 0, num_checks = 0, nx = 0;
    always #50 clk = ~clk;
    // Descriptor memory: word 0 points at 0x300, word 1 holds count 0 with the last flag.
    assign mem_rdata = mem_addr_q[2] ? 32'h8000_0000 : 32'h0000_0300;
    icd_top icd_top_i (.*);
    icd_dev_model icd_dev_model_i (.*);
    always @(posedge clk)
    begin
        mem_ack <= #1 mem_req_q && !mem_ack;
        if (eop_q)
            eop_seen <= 1'b1;
        if (mem_ack && dack_q != 8'h00)
        begin
            nx <= nx + 1;
            {lwr, lsz, la} <= {mem_wr_q, mem_size_q, mem_addr_q};
        end
    end
    task chk(input logic [39:0] got, input logic [39:0] exp);
    begin
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Strobes are held long enough for the two-flop pin synchronisers on both edges.
    task io(input logic rd, input logic [15:0] a, input logic [7:0] d);
    begin
        @(posedge clk) #1;
        {io_addr, io_data_in} = {a, d};
        repeat (3) @(posedge clk) #1;
        {io_rd_b, io_wr_b} = {!rd, rd};
        repeat (6) @(posedge clk) #1;
        q = io_data_oe_q ? {1'b1, io_data_out_q} : 9'h000;
        {io_rd_b, io_wr_b} = 2'b11;
        repeat (6) @(posedge clk) #1;
    end
    endtask
    task xfer(input int ch, input logic [33:0] e, input logic eop);
        int n;
    begin
        n = nx;
        eop_seen = 1'b0;
        want[ch] = 1'b1;
        for (int i = 0; i < 200 && nx == n; i++)
            @(posedge clk) #1;
        want[ch] = 1'b0;
        repeat (10) @(posedge clk) #1;
        chk({2'(nx - n), eop_seen, lwr, lsz, la}, {2'd1, eop, 1'b1, e});
    end
    endtask
    task automatic s_regs;
        logic [23:0] t[4] = '{24'h000C_00, 24'h0000_34, 24'h0000_12, 24'h000C_00};
    begin
        foreach (t[i]) io(1'b0, t[i][23:8], t[i][7:0]);
        io(1'b1, 16'h0000, 8'h00);
        chk(q, 9'h134);
        io(1'b1, 16'h0000, 8'h00);
        chk(q, 9'h112);
        io(1'b1, 16'h0300, 8'h00);
        chk(q, 9'h000);
    end
    endtask
    task automatic s_word;
        logic [23:0] t[10] = '{24'h00D8_00, 24'h00C4_10, 24'h00C4_00, 24'h00C6_00, 24'h00C6_00,
                               24'h008B_04, 24'h00D6_C0, 24'h00D6_45, 24'h00D4_00, 24'h00D4_01};
    begin
        foreach (t[i]) io(1'b0, t[i][23:8], t[i][7:0]);
        want[4] = 1'b1;
        xfer(5, {`ICD_SZ_WORD, 32'h0004_0020}, 1'b1);
        want[4] = 1'b0;
    end
    endtask
    task automatic s_byte;
        logic [23:0] t[8] = '{24'h000C_00, 24'h0002_00, 24'h0002_01, 24'h0003_01, 24'h0003_00,
                              24'h0083_02, 24'h000B_45, 24'h000A_01};
    begin
        foreach (t[i]) io(1'b0, t[i][23:8], t[i][7:0]);
        xfer(1, {`ICD_SZ_BYTE, 32'h0002_0100}, 1'b0);
        xfer(1, {`ICD_SZ_BYTE, 32'h0002_0101}, 1'b1);
        io(1'b1, 16'h0008, 8'h00);
        chk(q & 9'h10F, 9'h102);
    end
    endtask
    task automatic s_sg;
        logic [23:0] t[6] = '{24'h000A_01, 24'h0414_00, 24'h0415_10, 24'h0416_00, 24'h0417_00, 24'h0410_11};
    begin
        foreach (t[i]) io(1'b0, t[i][23:8], t[i][7:0]);
        xfer(1, {`ICD_SZ_BYTE, 32'h0000_0300}, 1'b1);
        io(1'b1, 16'h0410, 8'h00);
        chk(q, 9'h112);
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        repeat (3) @(posedge clk) #1;
        rst_b = 1'b1;
        repeat (6) @(posedge clk) #1;
        s_regs;
        s_word;
        s_byte;
        s_sg;
        end_of_test;
    end
    initial
    begin
        #500000;
        fails++;
        end_of_test;
    end
endmodule
`default_nettype wire
